/* File: inc/spi_flash_map.vh */
// Constants for the serial flash instruction engine.
// Assumes a 50 MHz system clock and the 2-Mbit array organisation.
`ifndef SPI_FLASH_MAP_VH
`define SPI_FLASH_MAP_VH

`define CLK_PERIOD_NS 20

// Instruction codes
`define OP_WRITE_ENABLE 8'h06
`define OP_FAST_READ 8'h0B
`define OP_PAGE_REWRITE 8'h0A
`define OP_PAGE_PROGRAM 8'h02
`define OP_PAGE_ERASE 8'hDB
`define OP_SECTOR_ERASE 8'hD8

// Array layout: 18 live address bits (17 on the 1-Mbit variant)
`define ADDR_BITS 18
`define PAGE_BITS 8
`define PAGE_BYTES 256
`define SECTOR_BITS 16
`define SECTOR_BYTES 65536
`define BYTE_ERASED 8'hFF

// Self-timed cycle lengths in microseconds
`define PAGE_REWRITE_TIME_US 1000
`define PAGE_PROGRAM_TIME_US 500
`define PAGE_ERASE_TIME_US 1000
`define SECTOR_ERASE_TIME_US 2000

// Read prefetch buffer
`define FIFO_WIDTH 8
`define FIFO_DEPTH 16
`define FIFO_AW 4

// Reset values of the filtered pin vector {lock_n, mosi, cs_n, sck}
`define PIN_RESET 4'hA

`endif

/* File: design/spi_flash_rwe.v */
// Serial flash instruction engine: fast read, page rewrite, page program,
// page and sector erase, with write enable latch and busy cycle.
// Assumes sck, cs_n, mosi and top_lock_n arrive asynchronously and that
// the serial clock is at most one eighth of clk.
`include "spi_flash_map.vh"

module prefetch_fifo #(
	parameter WIDTH = `FIFO_WIDTH,
	parameter DEPTH = `FIFO_DEPTH,
	parameter AW = `FIFO_AW
) (
	input wire clk,
	input wire sys_rst,
	input wire flush,
	input wire in_valid,
	output wire in_ready,
	input wire [WIDTH-1:0] in_data,
	output wire out_valid,
	input wire out_ready,
	output wire [WIDTH-1:0] out_data
);
	reg [WIDTH-1:0] mem_q [0:DEPTH-1];
	reg [AW-1:0] wr_q;
	reg [AW-1:0] rd_q;
	localparam [AW:0] FULL = DEPTH;
	reg [AW:0] cnt_q;
	wire push;
	wire pop;

	assign in_ready = (cnt_q != FULL);
	assign out_valid = (cnt_q != {(AW+1){1'b0}});
	assign out_data = mem_q[rd_q];
	assign push = in_valid & in_ready;
	assign pop = out_valid & out_ready;

	always @(posedge clk) begin
		if (push) begin
			mem_q[wr_q] <= in_data;
		end
	end

	always @(posedge clk) begin
		if (sys_rst || flush) begin
			wr_q <= {AW{1'b0}};
			rd_q <= {AW{1'b0}};
			cnt_q <= {(AW+1){1'b0}};
		end else begin
			if (push) begin
				wr_q <= wr_q + 1'b1;
			end
			if (pop) begin
				rd_q <= rd_q + 1'b1;
			end
			if (push && !pop) begin
				cnt_q <= cnt_q + 1'b1;
			end else if (pop && !push) begin
				cnt_q <= cnt_q - 1'b1;
			end
		end
	end
endmodule // prefetch_fifo

module spi_flash_rwe #(
	parameter [31:0] PAGE_REWRITE_CYCLES =
		`PAGE_REWRITE_TIME_US * 1000 / `CLK_PERIOD_NS,
	parameter [31:0] PAGE_PROGRAM_CYCLES =
		`PAGE_PROGRAM_TIME_US * 1000 / `CLK_PERIOD_NS,
	parameter [31:0] PAGE_ERASE_CYCLES =
		`PAGE_ERASE_TIME_US * 1000 / `CLK_PERIOD_NS,
	parameter [31:0] SECTOR_ERASE_CYCLES =
		`SECTOR_ERASE_TIME_US * 1000 / `CLK_PERIOD_NS
) (
	input wire clk,
	input wire sys_rst,
	input wire sck,
	input wire cs_n,
	input wire mosi,
	input wire top_lock_n,
	output reg miso,
	output reg miso_oe,
	output reg busy_flag,
	output reg write_enable_latch
);
	localparam AB = `ADDR_BITS;
	localparam [6:0] S_IDLE = 7'h01;
	localparam [6:0] S_OPC = 7'h02;
	localparam [6:0] S_ADDR = 7'h04;
	localparam [6:0] S_DUMMY = 7'h08;
	localparam [6:0] S_RDATA = 7'h10;
	localparam [6:0] S_WDATA = 7'h20;
	localparam [6:0] S_IGNORE = 7'h40;
	localparam [3:0] K_REWRITE = 4'h1;
	localparam [3:0] K_PROGRAM = 4'h2;
	localparam [3:0] K_PERASE = 4'h4;
	localparam [3:0] K_SERASE = 4'h8;

	// Pin synchronisers; a change counts once stages two and three agree
	reg [3:0] s1_q;
	reg [3:0] s2_q;
	reg [3:0] s3_q;
	reg [3:0] pin_q;
	wire [3:0] pin_d;
	assign pin_d = (s2_q & s3_q) | (pin_q & (s2_q | s3_q));

	always @(posedge clk) begin
		if (sys_rst) begin
			s1_q <= `PIN_RESET;
			s2_q <= `PIN_RESET;
			s3_q <= `PIN_RESET;
			pin_q <= `PIN_RESET;
		end else begin
			s1_q <= {top_lock_n, mosi, cs_n, sck};
			s2_q <= s1_q;
			s3_q <= s2_q;
			pin_q <= pin_d;
		end
	end

	wire sck_rise = pin_d[0] & ~pin_q[0];
	wire sck_fall = ~pin_d[0] & pin_q[0];
	wire cs_fall = ~pin_d[1] & pin_q[1];
	wire cs_rise = pin_d[1] & ~pin_q[1];
	wire locked = ~pin_q[3];

	reg [6:0] st_q;
	reg [2:0] bit_q;
	reg [2:0] byte_q;
	reg [6:0] sh_q;
	reg [7:0] op_q;
	reg [15:0] ahi_q;
	reg [AB-1:0] addr_q;
	reg arm_q;
	reg [7:0] col_q;
	reg fetch_q;
	reg [AB-1:0] fetch_addr_q;
	reg [7:0] out_q;
	reg [7:0] pbuf_q [0:`PAGE_BYTES-1];
	reg [`PAGE_BYTES-1:0] pval_q;
	reg [7:0] mem_q [0:(1<<AB)-1];

	reg [3:0] kind_q;
	reg [AB-1:0] base_q;
	reg [16:0] iter_q;
	reg [16:0] span_q;
	reg [31:0] tmr_q;

	wire [7:0] byte_in = {sh_q, pin_d[2]};
	wire byte_done = sck_rise & ~st_q[0] & (bit_q == 3'd7);
	wire is_write = (byte_in == `OP_PAGE_REWRITE) |
		(byte_in == `OP_PAGE_PROGRAM) | (byte_in == `OP_PAGE_ERASE) |
		(byte_in == `OP_SECTOR_ERASE);
	wire op_erase = (op_q == `OP_PAGE_ERASE) | (op_q == `OP_SECTOR_ERASE);
	wire op_data = (op_q == `OP_PAGE_REWRITE) | (op_q == `OP_PAGE_PROGRAM);
	wire [AB-1:0] addr_full = {ahi_q[AB-9:0], byte_in};
	wire top_sector = &addr_q[AB-1:`SECTOR_BITS];

	// Read prefetch path
	wire fifo_in_ready;
	wire fifo_out_valid;
	wire [7:0] fifo_out_data;
	wire pop = byte_done & (st_q[3] | st_q[4]);

	prefetch_fifo #(
		.WIDTH(`FIFO_WIDTH),
		.DEPTH(`FIFO_DEPTH),
		.AW(`FIFO_AW)
	) u_fifo (
		.clk(clk),
		.sys_rst(sys_rst),
		.flush(cs_fall | cs_rise),
		.in_valid(fetch_q),
		.in_ready(fifo_in_ready),
		.in_data(mem_q[fetch_addr_q]),
		.out_valid(fifo_out_valid),
		.out_ready(pop),
		.out_data(fifo_out_data)
	);

	// Validity of the instruction at the select rise
	wire edge_ok = (bit_q == 3'd0) & arm_q;
	wire data_ok = edge_ok & op_data & (byte_q == 3'd5);
	wire erase_ok = edge_ok & op_erase & (byte_q == 3'd4);
	wire prot = locked & top_sector;
	wire start = cs_rise & ~busy_flag & (data_ok | erase_ok) & ~prot;
	wire write_enable_cmd_ok = cs_rise & ~busy_flag & (op_q == `OP_WRITE_ENABLE) &
		(byte_q == 3'd1) & (bit_q == 3'd0);

	always @(posedge clk) begin
		if (sys_rst) begin
			st_q <= S_IDLE;
			bit_q <= 3'd0;
			byte_q <= 3'd0;
			sh_q <= 7'h00;
			op_q <= 8'h00;
			ahi_q <= 16'h0000;
			addr_q <= {AB{1'b0}};
			arm_q <= 1'b0;
			col_q <= 8'h00;
			fetch_q <= 1'b0;
			fetch_addr_q <= {AB{1'b0}};
			out_q <= 8'h00;
			pval_q <= {`PAGE_BYTES{1'b0}};
			miso <= 1'b0;
			miso_oe <= 1'b0;
		end else if (cs_fall) begin
			st_q <= S_OPC;
			bit_q <= 3'd0;
			byte_q <= 3'd0;
			arm_q <= 1'b0;
			fetch_q <= 1'b0;
		end else if (cs_rise) begin
			st_q <= S_IDLE;
			fetch_q <= 1'b0;
			miso_oe <= 1'b0;
		end else begin
			if (fetch_q && fifo_in_ready) begin
				fetch_addr_q <= fetch_addr_q + 1'b1;
			end
			if (sck_fall && st_q[4]) begin
				miso <= out_q[7];
				miso_oe <= 1'b1;
				out_q <= {out_q[6:0], 1'b0};
			end
			if (sck_rise && !st_q[0]) begin
				bit_q <= bit_q + 1'b1;
				sh_q <= byte_in[6:0];
			end
			if (byte_done) begin
				if (byte_q != 3'd5) begin
					byte_q <= byte_q + 1'b1;
				end
				case (st_q)
				S_OPC: begin
					op_q <= byte_in;
					if (busy_flag) begin
						st_q <= S_IGNORE;
					end else if (byte_in == `OP_FAST_READ) begin
						st_q <= S_ADDR;
					end else if (is_write && write_enable_latch) begin
						st_q <= S_ADDR;
					end else begin
						st_q <= S_IGNORE;
					end
				end
				S_ADDR: begin
					ahi_q <= {ahi_q[7:0], byte_in};
					if (byte_q == 3'd3) begin
						addr_q <= addr_full;
						col_q <= byte_in;
						if (op_q == `OP_FAST_READ) begin
							st_q <= S_DUMMY;
							fetch_q <= 1'b1;
							fetch_addr_q <= addr_full;
						end else if (op_data) begin
							st_q <= S_WDATA;
							arm_q <= 1'b1;
							pval_q <= {`PAGE_BYTES{1'b0}};
						end else begin
							st_q <= S_IGNORE;
							arm_q <= 1'b1;
						end
					end
				end
				S_DUMMY: begin
					st_q <= S_RDATA;
					// Empty buffer cannot occur at the rated clock ratio
					out_q <= fifo_out_valid ? fifo_out_data : `BYTE_ERASED;
				end
				S_RDATA: begin
					out_q <= fifo_out_valid ? fifo_out_data : `BYTE_ERASED;
				end
				S_WDATA: begin
					col_q <= col_q + 1'b1;
					pval_q[col_q] <= 1'b1;
				end
				S_IGNORE: begin
					st_q <= S_IGNORE;
				end
				default: begin
					st_q <= S_IGNORE;
				end
				endcase
			end
		end
	end

	// Page buffer; later bytes overwrite earlier ones at the same column
	always @(posedge clk) begin
		if (byte_done && st_q[5] && !cs_rise && !cs_fall) begin
			pbuf_q[col_q] <= byte_in;
		end
	end

	// Self-timed cycle: one array byte per clock, then wait out the timer
	wire [AB-1:0] idx = base_q + {1'b0, iter_q};
	wire [7:0] col = iter_q[7:0];
	wire [7:0] old = mem_q[idx];
	wire working = busy_flag & (iter_q != span_q);
	reg [7:0] wdat;

	always @* begin
		if (kind_q[0]) begin
			wdat = pval_q[col] ? pbuf_q[col] : old;
		end else if (kind_q[1]) begin
			wdat = pval_q[col] ? (old & pbuf_q[col]) : old;
		end else begin
			wdat = `BYTE_ERASED;
		end
	end

	always @(posedge clk) begin
		if (working) begin
			mem_q[idx] <= wdat;
		end
	end

	always @(posedge clk) begin
		if (sys_rst) begin
			busy_flag <= 1'b0;
			write_enable_latch <= 1'b0;
			kind_q <= 4'h0;
			base_q <= {AB{1'b0}};
			iter_q <= 17'h0_0000;
			span_q <= 17'h0_0000;
			tmr_q <= 32'h0000_0000;
		end else if (start) begin
			busy_flag <= 1'b1;
			write_enable_latch <= 1'b0;
			iter_q <= 17'h0_0000;
			if (op_q == `OP_SECTOR_ERASE) begin
				kind_q <= K_SERASE;
				base_q <= {addr_q[AB-1:`SECTOR_BITS], 16'h0000};
				span_q <= 17'h1_0000;
				tmr_q <= SECTOR_ERASE_CYCLES;
			end else begin
				base_q <= {addr_q[AB-1:`PAGE_BITS], 8'h00};
				span_q <= 17'h0_0100;
				if (op_q == `OP_PAGE_REWRITE) begin
					kind_q <= K_REWRITE;
					tmr_q <= PAGE_REWRITE_CYCLES;
				end else if (op_q == `OP_PAGE_PROGRAM) begin
					kind_q <= K_PROGRAM;
					tmr_q <= PAGE_PROGRAM_CYCLES;
				end else begin
					kind_q <= K_PERASE;
					tmr_q <= PAGE_ERASE_CYCLES;
				end
			end
		end else if (busy_flag) begin
			if (working) begin
				iter_q <= iter_q + 1'b1;
			end
			if (tmr_q != 32'h0000_0000) begin
				tmr_q <= tmr_q - 1'b1;
			end else if (!working) begin
				busy_flag <= 1'b0;
				kind_q <= 4'h0;
			end
		end else if (write_enable_cmd_ok) begin
			write_enable_latch <= 1'b1;
		end
	end
endmodule // spi_flash_rwe

/* File: bench/spi_flash_rwe_props.sv */
// Pin assertions for the serial flash engine.
// Assumes sck at most clk/8; bound to spi_flash_rwe.
module spi_flash_rwe_props (
	input logic clk,
	input logic sys_rst,
	input logic sck,
	input logic cs_n,
	input logic mosi,
	input logic top_lock_n,
	input logic miso,
	input logic miso_oe,
	input logic busy_flag,
	input logic write_enable_latch
);
	timeunit 1ns;
	timeprecision 1ps;
	default clocking @(posedge clk);
	endclocking
	default disable iff (sys_rst);
	sequence cs_idle;
		cs_n [*8];
	endsequence
	sequence cycle_start;
		$rose(busy_flag);
	endsequence
	oe_release_a:
		assert property (cs_idle |-> !miso_oe)
		else $error("output enabled while deselected");
	oe_select_a:
		assert property ($rose(miso_oe) |-> !cs_n && !busy_flag)
		else $error("output enabled outside a read");
	busy_start_a:
		assert property (cycle_start |-> cs_n && $past(cs_n))
		else $error("cycle started while selected");
	busy_hold_a:
		assert property (cycle_start |=> busy_flag [*8])
		else $error("busy dropped early");
	latch_clear_a:
		assert property (cycle_start |-> ##[0:2] !write_enable_latch)
		else $error("latch kept at cycle start");
	latch_end_a:
		assert property ($fell(busy_flag) |-> !write_enable_latch)
		else $error("latch set at cycle end");
	latch_set_a:
		assert property ($rose(write_enable_latch) |-> cs_n && !busy_flag)
		else $error("latch set while busy or selected");
	miso_hold_a:
		assert property ($rose(sck) && !cs_n |=> ##1 ($stable(miso)) [*2])
		else $error("data changed in clock high phase");
endmodule // spi_flash_rwe_props

bind spi_flash_rwe spi_flash_rwe_props chk (
	.clk(clk),
	.sys_rst(sys_rst),
	.sck(sck),
	.cs_n(cs_n),
	.mosi(mosi),
	.top_lock_n(top_lock_n),
	.miso(miso),
	.miso_oe(miso_oe),
	.busy_flag(busy_flag),
	.write_enable_latch(write_enable_latch)
);

/* File: bench/host_model.sv */
// Behavioural SPI host, mode 0.
// Assumes clk is the bench clock; half period of sck is 4 clk plus gap.
module host_model (
	input logic clk,
	output logic sck,
	output logic cs_n,
	output logic mosi,
	input logic miso
);
	timeunit 1ns;
	timeprecision 1ps;
	int gap = 0;
	initial begin
		sck = 1'b0;
		cs_n = 1'b1;
		mosi = 1'b0;
	end
	task automatic tick(input int n);
		repeat (n) @(posedge clk);
	endtask
	task automatic start();
		tick(1);
		cs_n <= 1'b0;
		tick(8);
	endtask
	task automatic bits(input [7:0] d, input int n, output [7:0] q);
		q = 8'h00;
		for (int i = 7; i > 7 - n; i--) begin
			mosi <= d[i];
			tick(4 + gap);
			sck <= 1'b1;
			tick(4 + gap);
			q[i] = miso;
			sck <= 1'b0;
		end
	endtask
	task automatic stop();
		tick(4);
		cs_n <= 1'b1;
		mosi <= ~mosi;
		tick(12);
	endtask
endmodule // host_model

/* File: bench/tb_spi_flash_read_write_erase.sv */
// Self-checking bench for the serial flash engine.
// Assumes design, map header and host_model are compiled first.
`include "spi_flash_map.vh"
module tb_spi_flash_read_write_erase;
	timeunit 1ns;
	timeprecision 1ps;
	logic clk = 1'b0;
	logic sys_rst = 1'b1;
	logic top_lock_n = 1'b1;
	wire sck, cs_n, mosi, miso, miso_oe, busy_flag, write_enable_latch;
	int n_errors = 0;
	int check_count = 0;
	logic [15:0] rnd = 16'h0015;
	logic [7:0] exp_mem [256];
	logic [7:0] dat [300];
	logic [7:0] got [300];
	initial begin
		forever #10 clk = ~clk;
	end
	// Short cycles keep the run brief; sector erase never runs
	spi_flash_rwe #(
		.PAGE_REWRITE_CYCLES(32'h0000_0BB8),
		.PAGE_PROGRAM_CYCLES(32'h0000_0BB8),
		.PAGE_ERASE_CYCLES(32'h0000_0BB8),
		.SECTOR_ERASE_CYCLES(32'h0001_1170)
	) uut (
		.clk(clk), .sys_rst(sys_rst), .sck(sck), .cs_n(cs_n),
		.mosi(mosi), .top_lock_n(top_lock_n), .miso(miso),
		.miso_oe(miso_oe), .busy_flag(busy_flag),
		.write_enable_latch(write_enable_latch)
	);
	host_model host (.clk(clk), .sck(sck), .cs_n(cs_n), .mosi(mosi),
		.miso(miso));
	function automatic [7:0] rnd8();
		rnd = {rnd[14:0], rnd[15] ^ rnd[13] ^ rnd[12] ^ rnd[10]};
		return rnd[7:0];
	endfunction
	function automatic [7:0] merge(input [7:0] op, old, d);
		return (op == `OP_PAGE_PROGRAM) ? (old & d) : d;
	endfunction
	task automatic check(input string what, input [7:0] seen, want);
		check_count++;
		if (seen !== want) begin
			n_errors++;
			$display("BAD %s expected %h seen %h", what, want, seen);
		end
	endtask
	task automatic complete_run();
		$display("checks %0d mismatches %0d", check_count, n_errors);
		if (n_errors == 0 && check_count > 0) begin
			$display("No errors found");
		end else begin
			$display("Errors were found");
		end
		$finish;
	endtask
	task automatic frame(input [7:0] op, input [23:0] a, input int n, x);
		logic [7:0] q;
		host.gap = (rnd[1:0] == 2'b00) ? 1 : 0;
		host.start();
		host.bits(op, 8, q);
		for (int i = 23; i > 0 && op != `OP_WRITE_ENABLE; i -= 8)
			host.bits(a[i -: 8], 8, q);
		for (int k = 0; k < n; k++) begin
			dat[k] = rnd8();
			host.bits(dat[k], 8, got[k]);
		end
		if (x > 0)
			host.bits(rnd8(), x, q);
		host.stop();
	endtask
	task automatic wait_idle();
		int t;
		t = 0;
		while (busy_flag !== 1'b0 && t < 5000) begin
			@(posedge clk);
			t++;
		end
		check("idle", {7'h00, busy_flag}, 8'h00);
	endtask
	task automatic read_check();
		frame(`OP_FAST_READ, 24'hFF_FFFF, 258, 0);
		for (int j = 0; j < 256; j++)
			check("read", got[j + 2], exp_mem[j]);
		$display("read test done");
	endtask
	task automatic write_op(input [7:0] op, col, input int n);
		logic [7:0] g;
		logic [7:0] a;
		g = rnd8();
		frame(`OP_WRITE_ENABLE, 24'h00_0000, 0, 0);
		check("latch", write_enable_latch, 8'h01);
		frame(op, {g[5:0], 10'h000, col}, n, 0);
		check("busy", busy_flag, 8'h01);
		check("latch", write_enable_latch, 8'h00);
		for (int k = 0; k < n; k++) begin
			a = col + k[7:0];
			exp_mem[a] = merge(op, exp_mem[a], dat[k]);
		end
		wait_idle();
		$display("write test done");
	endtask
	task automatic refused(input [7:0] op, input [23:0] a, input int n, x,
		input bit wr);
		if (wr)
			frame(`OP_WRITE_ENABLE, 24'h00_0000, 0, 0);
		frame(op, a, n, x);
		check("busy", busy_flag, 8'h00);
		check("latch", write_enable_latch, {7'h00, wr});
		$display("refusal test done");
	endtask
	initial begin
		repeat (20) @(posedge clk);
		sys_rst <= 1'b0;
		repeat (8) @(posedge clk);
		frame(`OP_WRITE_ENABLE, 24'h00_0000, 0, 0);
		frame(`OP_PAGE_ERASE, 24'hC0_00AB, 0, 0);
		frame(`OP_FAST_READ, 24'h00_0000, 4, 0);
		frame(`OP_WRITE_ENABLE, 24'h00_0000, 0, 0);
		frame(`OP_PAGE_PROGRAM, 24'h00_0000, 4, 0);
		check("busy", busy_flag, 8'h01);
		check("latch", write_enable_latch, 8'h00);
		wait_idle();
		foreach (exp_mem[j])
			exp_mem[j] = 8'hFF;
		write_op(`OP_PAGE_PROGRAM, 8'hF0, 20);
		write_op(`OP_PAGE_PROGRAM, 8'hF8, 16);
		read_check();
		write_op(`OP_PAGE_REWRITE, 8'h80, 260);
		write_op(`OP_PAGE_REWRITE, 8'h05, 3);
		refused(`OP_PAGE_PROGRAM, 24'h00_0000, 2, 0, 0);
		refused(`OP_SECTOR_ERASE, 24'h00_0000, 0, 0, 0);
		refused(`OP_PAGE_PROGRAM, 24'h00_0010, 2, 3, 1);
		refused(`OP_PAGE_REWRITE, 24'h00_0010, 0, 0, 1);
		refused(`OP_PAGE_ERASE, 24'h00_0010, 1, 0, 1);
		refused(`OP_SECTOR_ERASE, 24'h00_0010, 0, 2, 1);
		top_lock_n <= 1'b0;
		refused(`OP_PAGE_ERASE, 24'h03_FF00, 0, 0, 1);
		refused(`OP_SECTOR_ERASE, 24'h03_0000, 0, 0, 1);
		refused(`OP_PAGE_REWRITE, 24'h03_0010, 1, 0, 1);
		top_lock_n <= 1'b1;
		read_check();
		frame(`OP_FAST_READ, 24'h00_0000, 2, 3);
		check("oe", {7'h00, miso_oe}, 8'h00);
		complete_run();
	end
	initial begin
		repeat (99000) @(posedge clk);
		n_errors++;
		complete_run();
	end
endmodule // tb_spi_flash_read_write_erase
